// [design/rtcaw_top.sv]
// Summary of operation
// - Time is held in a 32-bit seconds counter and an 8-bit subsecond counter.
// - A 256 Hz reference divided from the 32.768 kHz oscillator steps the subsecond count.
// - Each subsecond overflow is a 1 Hz tick that adds one to the seconds counter.
// - Clock and oscillator logic keep running while the rest of the device sleeps.
// - With the alarm enabled, its flag sets when the alarm value equals the low 20 bits of seconds.
// - A firing alarm clears the alarm enable bit by itself.
// - A firing alarm takes the device out of sleep.
// - Writing one to the watchdog enable bit starts the watchdog.
// - Enabled and unserviced for 500 ms, the watchdog drives reset for 250 ms.
// - Since sampling is on a free tick, the timeout lands between 500 ms and 750 ms.
// - Writing zero to the watchdog enable bit stops any further watchdog reset.
// - Clock, alarm and watchdog are all timed from the 32.768 kHz oscillator.
// - Alarm status is a maskable source of the interrupt output.
`timescale 1ns/100ps
`default_nettype none

module rtcaw_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic osc_32k_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    output logic wdt_reset_out,
    output logic sleep_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic osc_q;
    logic osc_rise;

    logic [31:0] seconds;
    logic [31:0] next_seconds;
    logic [7:0] subsec;
    logic [7:0] sub_stage;
    logic [7:0] sub_snap;
    logic [19:0] alarm_match_value;
    logic alarm_enable;
    logic watchdog_enable;
    logic sleep;
    logic [1:0] int_status;
    logic [1:0] interrupt_mask_register;
    logic [1:0] next_int_status;
    logic sec_tick_q;

    logic sub_step;
    logic sec_tick;
    logic quarter_tick;
    logic wd_reset;
    logic wd_bite;
    logic alarm_fire;

    logic wr_seconds;
    logic wr_subsec;
    logic wr_alarm;
    logic wr_ctrl;
    logic wr_service;
    logic wr_int_status;
    logic wr_int_mask;
    logic rd_seconds;
    logic [31:0] read_mux;
    logic [31:0] next_rdata;
    logic [31:0] ctrl_word;
    logic [31:0] state_word;
    logic [1:0] int_set;
    logic [1:0] int_clear;
    logic irq_level;

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator edge and prescaler

    // Every timebase step comes from an oscillator edge
    assign osc_rise = osc_32k_in && !osc_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= osc_32k_in;
        end
    end

    // Divide by 128 down to the 256 Hz reference
    rtcaw_tick_div #(
        .WIDTH(rtcaw_pkg::PRESCALE_W),
        .LAST(rtcaw_pkg::PRESCALE_LAST)
    ) u_prescale (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(1'b0),
        .load_in(1'b0),
        .load_value_in(7'h00),
        .step_in(osc_rise),
        .count_out(),
        .tick_out(sub_step)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Subsecond and seconds counters

    // Subsecond counter; its wrap is the 1 Hz tick
    rtcaw_tick_div #(
        .WIDTH(rtcaw_pkg::SUB_W),
        .LAST(rtcaw_pkg::SUB_LAST)
    ) u_subsec (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(1'b0),
        .load_in(wr_seconds),
        .load_value_in(sub_stage),
        .step_in(sub_step),
        .count_out(subsec),
        .tick_out(sec_tick)
    );

    // Host load wins over a tick in the same cycle
    always_comb begin
        next_seconds = seconds;
        if (wr_seconds) begin
            next_seconds = wdata_in;
        end else if (sec_tick) begin
            next_seconds = 32'(seconds + 1'b1);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seconds <= rtcaw_pkg::SEC_RESET;
        end else begin
            seconds <= next_seconds;
        end
    end

    // Staged subseconds commit with the seconds word; read snapshot pairs them
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sub_stage <= rtcaw_pkg::SUB_RESET;
        end else if (wr_subsec) begin
            sub_stage <= wdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sub_snap <= rtcaw_pkg::SUB_RESET;
        end else if (rd_seconds) begin
            sub_snap <= subsec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Quarter-second timebase for the watchdog

    rtcaw_tick_div #(
        .WIDTH(rtcaw_pkg::WD_QUARTER_W),
        .LAST(rtcaw_pkg::WD_QUARTER_LAST)
    ) u_quarter (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(1'b0),
        .load_in(1'b0),
        .load_value_in(6'h00),
        .step_in(sub_step),
        .count_out(),
        .tick_out(quarter_tick)
    );

    // Timeout counted in free-running quarter ticks
    rtcaw_watchdog u_watchdog (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .enable_in(watchdog_enable),
        .service_in(wr_service),
        .quarter_tick_in(quarter_tick),
        .sub_tick_in(sub_step),
        .reset_out(wd_reset),
        .bite_out(wd_bite)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Time-of-day alarm

    // Compared one cycle after the seconds step, against the new count
    assign alarm_fire = sec_tick_q && alarm_enable
        && (seconds[rtcaw_pkg::ALARM_W-1:0] == alarm_match_value);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sec_tick_q <= 1'b0;
        end else begin
            sec_tick_q <= sec_tick && !wr_seconds;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    assign wr_seconds = wr_in && (addr_in == rtcaw_pkg::OFF_SECONDS);
    assign wr_subsec = wr_in && (addr_in == rtcaw_pkg::OFF_SUBSEC);
    assign wr_alarm = wr_in && (addr_in == rtcaw_pkg::OFF_ALARM);
    assign wr_ctrl = wr_in && (addr_in == rtcaw_pkg::OFF_CTRL);
    assign wr_service = wr_in && (addr_in == rtcaw_pkg::OFF_WD_SERVICE);
    assign wr_int_status = wr_in && (addr_in == rtcaw_pkg::OFF_INT_STATUS);
    assign wr_int_mask = wr_in && (addr_in == rtcaw_pkg::OFF_INT_MASK);
    assign rd_seconds = rd_in && (addr_in == rtcaw_pkg::OFF_SECONDS);

    ////////////////////////////////////////////////////////////////////////////////
    // Control, alarm value and sleep

    // Alarm seconds at 1 s resolution
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_match_value <= rtcaw_pkg::ALARM_RESET;
        end else if (wr_alarm) begin
            alarm_match_value <= wdata_in[rtcaw_pkg::ALARM_W-1:0];
        end
    end

    // Watchdog enable, also its stop control
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            watchdog_enable <= 1'b0;
        end else if (wr_ctrl) begin
            watchdog_enable <= wdata_in[rtcaw_pkg::CTRL_WD_EN_BIT];
        end
    end

    // Alarm trip clears the enable even against a host write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_enable <= 1'b0;
        end else if (alarm_fire) begin
            alarm_enable <= 1'b0;
        end else if (wr_ctrl) begin
            alarm_enable <= wdata_in[rtcaw_pkg::CTRL_AL_EN_BIT];
        end
    end

    // Wake on alarm wins over a sleep request
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sleep <= 1'b0;
        end else if (alarm_fire) begin
            sleep <= 1'b0;
        end else if (wr_ctrl) begin
            sleep <= wdata_in[rtcaw_pkg::CTRL_SLEEP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    assign int_set = {wd_bite, alarm_fire};
    assign int_clear = wr_int_status ? wdata_in[rtcaw_pkg::INT_W-1:0] : 2'h0;
    // Set wins over a write-one clear
    assign next_int_status = (int_status & ~int_clear) | int_set;
    assign irq_level = |(next_int_status & interrupt_mask_register);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_status <= 2'h0;
        end else begin
            int_status <= next_int_status;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            interrupt_mask_register <= rtcaw_pkg::INT_MASK_RESET;
        end else if (wr_int_mask) begin
            interrupt_mask_register <= wdata_in[rtcaw_pkg::INT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path

    assign ctrl_word = {29'h0, sleep, alarm_enable, watchdog_enable};
    assign state_word = {30'h0, wd_reset, sleep};

    always_comb begin
        read_mux = 32'h0000_0000;
        case (addr_in)
            rtcaw_pkg::OFF_SECONDS: read_mux = seconds;
            rtcaw_pkg::OFF_SUBSEC: read_mux = {24'h0, sub_snap};
            rtcaw_pkg::OFF_ALARM: read_mux = {12'h0, alarm_match_value};
            rtcaw_pkg::OFF_CTRL: read_mux = ctrl_word;
            rtcaw_pkg::OFF_INT_STATUS: read_mux = {30'h0, int_status};
            rtcaw_pkg::OFF_INT_MASK: read_mux = {30'h0, interrupt_mask_register};
            rtcaw_pkg::OFF_STATE: read_mux = state_word;
            default: read_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // Read data stand only in the slot after the strobe
    assign next_rdata = rd_in ? read_mux : 32'h0000_0000;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    // Level interrupt, aligned with the status register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_level;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wdt_reset_out <= 1'b0;
        end else begin
            wdt_reset_out <= wd_reset;
        end
    end

    // Sleep level for the power control
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sleep_out <= 1'b0;
        end else begin
            sleep_out <= sleep;
        end
    end

endmodule : rtcaw_top

`default_nettype wire

// [design/rtcaw_pkg.sv]
package rtcaw_pkg;

    // Register port
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    localparam logic [7:0] OFF_SECONDS = 8'h00;
    localparam logic [7:0] OFF_SUBSEC = 8'h04;
    localparam logic [7:0] OFF_ALARM = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_WD_SERVICE = 8'h10;
    localparam logic [7:0] OFF_INT_STATUS = 8'h14;
    localparam logic [7:0] OFF_INT_MASK = 8'h18;
    localparam logic [7:0] OFF_STATE = 8'h1C;

    // Control register fields
    localparam int unsigned CTRL_WD_EN_BIT = 0;
    localparam int unsigned CTRL_AL_EN_BIT = 1;
    localparam int unsigned CTRL_SLEEP_BIT = 2;

    // Interrupt status / mask fields
    localparam int unsigned INT_W = 2;
    localparam int unsigned INT_ALARM_BIT = 0;
    localparam int unsigned INT_WD_BIT = 1;

    // State register fields
    localparam int unsigned STATE_SLEEP_BIT = 0;
    localparam int unsigned STATE_WD_RST_BIT = 1;

    // Counter widths
    localparam int unsigned SEC_W = 32;
    localparam int unsigned SUB_W = 8;
    localparam int unsigned ALARM_W = 20;

    // Reset values
    localparam logic [31:0] SEC_RESET = 32'h0000_0000;
    localparam logic [7:0] SUB_RESET = 8'h00;
    localparam logic [19:0] ALARM_RESET = 20'h00000;
    localparam logic [1:0] INT_MASK_RESET = 2'h0;

    // Oscillator derived timing
    localparam int unsigned OSC_HZ = 32768;
    localparam int unsigned SUB_HZ = 256;
    localparam int unsigned PRESCALE = OSC_HZ / SUB_HZ;
    localparam int unsigned PRESCALE_W = 7;
    localparam logic [6:0] PRESCALE_LAST = 7'(PRESCALE - 1);
    localparam logic [7:0] SUB_LAST = 8'hFF;

    // Watchdog timing in milliseconds and in 256 Hz ticks
    localparam int unsigned WD_TIMEOUT_MS = 500;
    localparam int unsigned WD_HOLD_MS = 250;
    localparam int unsigned WD_QUARTER_TICKS = (SUB_HZ * WD_HOLD_MS) / 1000;
    localparam int unsigned WD_QUARTER_W = 6;
    localparam logic [5:0] WD_QUARTER_LAST = 6'(WD_QUARTER_TICKS - 1);
    localparam int unsigned WD_TIMEOUT_QUARTERS = WD_TIMEOUT_MS / WD_HOLD_MS;
    localparam logic [1:0] WD_BITE_COUNT = 2'(WD_TIMEOUT_QUARTERS);

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_WATCH,
        WD_HOLD
    } rtcaw_wd_state_e;

endpackage : rtcaw_pkg

// [design/rtcaw_tick_div.sv]
`timescale 1ns/100ps
`default_nettype none

module rtcaw_tick_div #(
    parameter int unsigned WIDTH = 8,
    parameter logic [WIDTH-1:0] LAST = '1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clear_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] load_value_in,
    input wire logic step_in,
    output logic [WIDTH-1:0] count_out,
    output logic tick_out
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic at_last;

    assign at_last = (count == LAST);
    assign tick_out = step_in && at_last && !load_in && !clear_in;
    assign count_out = count;

    always_comb begin
        next_count = count;
        if (clear_in) begin
            next_count = '0;
        end else if (load_in) begin
            next_count = load_value_in;
        end else if (step_in) begin
            next_count = at_last ? '0 : WIDTH'(count + 1'b1);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : rtcaw_tick_div

`default_nettype wire

// [design/rtcaw_watchdog.sv]
`timescale 1ns/100ps
`default_nettype none

module rtcaw_watchdog (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic service_in,
    input wire logic quarter_tick_in,
    input wire logic sub_tick_in,
    output logic reset_out,
    output logic bite_out
);

    rtcaw_pkg::rtcaw_wd_state_e state;
    rtcaw_pkg::rtcaw_wd_state_e next_state;
    logic [1:0] quarters;
    logic [1:0] next_quarters;
    logic [5:0] hold;
    logic [5:0] next_hold;
    logic bite;
    logic hold_done;

    // Bite on the first quarter tick after two whole unserviced quarters
    assign bite = (state == rtcaw_pkg::WD_WATCH) && enable_in && !service_in && quarter_tick_in
        && (quarters == rtcaw_pkg::WD_BITE_COUNT);
    assign hold_done = sub_tick_in && (hold == rtcaw_pkg::WD_QUARTER_LAST);

    always_comb begin
        next_state = state;
        next_quarters = quarters;
        next_hold = hold;
        case (state)
            rtcaw_pkg::WD_IDLE: begin
                next_quarters = 2'h0;
                if (enable_in) begin
                    next_state = rtcaw_pkg::WD_WATCH;
                end
            end
            rtcaw_pkg::WD_WATCH: begin
                if (!enable_in) begin
                    next_state = rtcaw_pkg::WD_IDLE;
                end else if (service_in) begin
                    next_quarters = 2'h0;
                end else if (bite) begin
                    next_state = rtcaw_pkg::WD_HOLD;
                    next_hold = 6'h00;
                end else if (quarter_tick_in) begin
                    next_quarters = 2'(quarters + 1'b1);
                end
            end
            rtcaw_pkg::WD_HOLD: begin
                if (!enable_in) begin
                    next_state = rtcaw_pkg::WD_IDLE;
                end else if (hold_done) begin
                    next_state = rtcaw_pkg::WD_WATCH;
                    next_quarters = 2'h0;
                end else if (sub_tick_in) begin
                    next_hold = 6'(hold + 1'b1);
                end
            end
            default: begin
                next_state = rtcaw_pkg::WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= rtcaw_pkg::WD_IDLE;
            quarters <= 2'h0;
            hold <= 6'h00;
        end else begin
            state <= next_state;
            quarters <= next_quarters;
            hold <= next_hold;
        end
    end

    assign reset_out = (state == rtcaw_pkg::WD_HOLD);
    assign bite_out = bite;

endmodule : rtcaw_watchdog

`default_nettype wire

// [verif/rtcaw_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

module rtcaw_host_model (
    input wire logic clk_in,
    output logic [7:0] addr_out,
    output logic [31:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [31:0] rdata_in
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 32'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // Released lines show the inverse of the last value
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(posedge clk_in);
        d = rdata_in;
    endtask : rd_reg

    // Whole 40-bit time, subseconds staged first
    task automatic wr_time(input logic [31:0] sec, input logic [31:0] sub);
        wr_reg(rtcaw_pkg::OFF_SUBSEC, sub);
        wr_reg(rtcaw_pkg::OFF_SECONDS, sec);
    endtask : wr_time

    task automatic rd_time(output logic [31:0] sec, output logic [31:0] sub);
        rd_reg(rtcaw_pkg::OFF_SECONDS, sec);
        rd_reg(rtcaw_pkg::OFF_SUBSEC, sub);
    endtask : rd_time
endmodule : rtcaw_host_model

`default_nettype wire

// [verif/rtcaw_properties.sv]
`timescale 1ns/100ps
`default_nettype none

module rtcaw_properties (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic osc_32k_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic irq_out,
    input wire logic wdt_reset_out,
    input wire logic sleep_out
);
    // Limits in oscillator edges: 500..750 ms and 250 ms
    localparam int WD_MIN = 16380;
    localparam int WD_MAX = 24580;
    localparam int HOLD_MIN = 8188;
    localparam int HOLD_MAX = 8196;

    logic osc_q;
    logic wd_sh;
    logic [1:0] mask_sh;
    logic [15:0] quiet_cnt;
    logic [15:0] hold_cnt;
    wire osc_edge = osc_32k_in & ~osc_q;
    wire ctrl_wr = wr_in && addr_in == rtcaw_pkg::OFF_CTRL;
    wire svc = (wr_in && addr_in == rtcaw_pkg::OFF_WD_SERVICE) || (ctrl_wr && !wd_sh);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_q <= 1'b0;
            wd_sh <= 1'b0;
            mask_sh <= 2'h0;
            quiet_cnt <= 16'h0;
            hold_cnt <= 16'h0;
        end else begin
            osc_q <= osc_32k_in;
            if (ctrl_wr) begin
                wd_sh <= wdata_in[rtcaw_pkg::CTRL_WD_EN_BIT];
            end
            if (wr_in && addr_in == rtcaw_pkg::OFF_INT_MASK) begin
                mask_sh <= wdata_in[1:0];
            end
            quiet_cnt <= (svc || wdt_reset_out) ? 16'h0 : quiet_cnt + 16'(osc_edge);
            hold_cnt <= !wdt_reset_out ? 16'h0 : hold_cnt + 16'(osc_edge);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_wd_bite;
        $rose(wdt_reset_out);
    endsequence
    sequence s_wd_release;
        $fell(wdt_reset_out) ##0 wd_sh;
    endsequence

    a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
    a_unmapped_read: assert property (rd_in && addr_in > 8'h1C |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_service_read: assert property (rd_in && addr_in == rtcaw_pkg::OFF_WD_SERVICE
        |=> rdata_out == 32'h0) else $error("service register read not zero");
    a_ctrl_readback: assert property (rd_in && addr_in == rtcaw_pkg::OFF_CTRL
        |=> rdata_out[0] == $past(wd_sh)) else $error("watchdog enable readback wrong");
    a_mask_readback: assert property (rd_in && addr_in == rtcaw_pkg::OFF_INT_MASK
        |=> rdata_out == {30'h0, $past(mask_sh)}) else $error("mask readback wrong");
    a_irq_masked: assert property (mask_sh == 2'h0 && $past(mask_sh) == 2'h0 |-> !irq_out)
        else $error("interrupt while fully masked");
    a_alarm_wake: assert property ($rose(irq_out) && mask_sh == 2'h1
        |-> ##[1:2] !sleep_out) else $error("alarm did not end sleep");
    a_wd_off_quiet: assert property (!wd_sh [*3] |-> !wdt_reset_out)
        else $error("watchdog reset while disabled");
    a_wd_timeout: assert property (s_wd_bite |-> quiet_cnt inside {[WD_MIN:WD_MAX]})
        else $error("watchdog timeout outside window");
    a_wd_hold_len: assert property (s_wd_release |-> hold_cnt inside {[HOLD_MIN:HOLD_MAX]})
        else $error("watchdog reset length wrong");
endmodule : rtcaw_properties

bind rtcaw_top rtcaw_properties i_props (.clk_in(clk_in), .rst_in(rst_in),
    .osc_32k_in(osc_32k_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .wdt_reset_out(wdt_reset_out), .sleep_out(sleep_out));

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic osc = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    logic irq;
    logic wdt;
    logic slp;
    logic [31:0] d;
    logic [31:0] s;
    logic [31:0] sb;
    logic [31:0] rs;
    logic [31:0] rsb;
    logic [19:0] al;
    int error_cnt = 0;
    int total_checks = 0;
    int seed;
    int n;

    always #5 clk_in = ~clk_in;
    // One oscillator edge every two clocks
    always @(posedge clk_in) osc <= ~osc;

    rtcaw_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .osc_32k_in(osc), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
        .wdt_reset_out(wdt), .sleep_out(slp));
    rtcaw_host_model i_host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd), .rdata_in(rdata));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        i_host.rd_reg(a, d);
        chk(nm, e, d);
    endtask : rdc

    task automatic wait_wdt(input logic lvl, input int lim);
        n = 0;
        while (wdt !== lvl && n < lim) begin
            @(posedge clk_in);
            n++;
        end
    endtask : wait_wdt

    task automatic finish_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h9E86;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 40; a += 4) begin
            rdc(8'(a), 32'h0, "reset_value");
        end
        repeat (4) begin
            s = $random(seed);
            sb = $random(seed) & 32'h7F;
            i_host.wr_time(s, sb);
            i_host.rd_time(rs, rsb);
            chk("seconds", s, rs);
            chk("subsec", sb, (rsb == sb + 32'h1) ? sb : rsb);
        end
        i_host.wr_time(32'hFFFF_FFFF, 32'hFF);
        repeat (270) @(posedge clk_in);
        rdc(rtcaw_pkg::OFF_SECONDS, 32'h0, "wrap");
        for (int i = 0; i < 3; i++) begin
            al = 20'($random(seed));
            i_host.wr_reg(rtcaw_pkg::OFF_INT_MASK, 32'(i != 1));
            i_host.wr_reg(rtcaw_pkg::OFF_ALARM, 32'(al));
            i_host.wr_reg(rtcaw_pkg::OFF_CTRL, (i < 2) ? 32'h6 : 32'h4);
            repeat (2) @(posedge clk_in);
            chk("sleep", 32'h1, 32'(slp));
            i_host.wr_time({12'($random(seed)), al - 20'h1}, 32'hFF);
            repeat (270) @(posedge clk_in);
            chk("irq", 32'(i == 0), 32'(irq));
            chk("wake", 32'(i == 2), 32'(slp));
            rdc(rtcaw_pkg::OFF_INT_STATUS, 32'(i < 2), "alarm_flag");
            rdc(rtcaw_pkg::OFF_CTRL, (i < 2) ? 32'h0 : 32'h4, "alarm_enable");
            i_host.wr_reg(rtcaw_pkg::OFF_INT_STATUS, 32'h1);
            i_host.wr_reg(rtcaw_pkg::OFF_CTRL, 32'h0);
            rdc(rtcaw_pkg::OFF_INT_STATUS, 32'h0, "flag_clear");
            chk("irq_clear", 32'h0, 32'(irq));
        end
        i_host.wr_reg(rtcaw_pkg::OFF_CTRL, 32'h1);
        i_host.wr_reg(rtcaw_pkg::OFF_WD_SERVICE, 32'h0);
        wait_wdt(1'b1, 50000);
        if (n == 50000) begin
            error_cnt++;
            finish_test();
        end
        chk("wd_timeout", 32'h1, 32'(n >= 32760 && n <= 49160));
        rdc(rtcaw_pkg::OFF_INT_STATUS, 32'h2, "wd_flag");
        rdc(rtcaw_pkg::OFF_STATE, 32'h2, "wd_state");
        wait_wdt(1'b0, 20000);
        chk("wd_hold", 32'h1, 32'(n >= 16370 && n <= 16400));
        i_host.wr_reg(rtcaw_pkg::OFF_CTRL, 32'h0);
        wait_wdt(1'b1, 20000);
        chk("wd_off", 32'd20000, 32'(n));
        finish_test();
    end
endmodule : tb

`default_nettype wire
